// >>> hdl/psrc_pkg.sv
package psrc_pkg;
  // interpolator geometry
  localparam int          STEPS_PER_PERIOD = 32;
  localparam int          STEP_W           = 5;
  localparam int          NUM_OUTPUTS      = 7;
  localparam int          NUM_PI           = NUM_OUTPUTS + 1;
  localparam int          FB_IDX           = NUM_OUTPUTS;
  // shift handshake timing, in shift clock cycles
  localparam int          DONE_LATENCY     = 12;
  localparam int          IDLE_DONE_PERIOD = 32;
  localparam int          CNT_W            = 6;
  // reconfiguration port
  localparam int          ADDR_W           = 7;
  localparam int          DATA_W           = 16;
  localparam int          NUM_REGS         = 128;
  localparam logic [15:0] REG_RESET        = 16'h0000;
  // sub-step slew resolution during one step
  localparam int          FRAC_W           = 4;
  // last sub-step index; the wait has one slew cycle fewer than the latency
  localparam int          SLEW_LAST        = DONE_LATENCY - 2;
  typedef enum logic [1:0] {
    PSRC_CTL_IDLE,
    PSRC_CTL_WAIT,
    PSRC_CTL_GAP
  } psrc_ctl_state_type;
endpackage

// >>> hdl/psrc_if.sv
`timescale 1ns/10ps
interface psrc_if;
  // fine phase shift handshake
  logic                             shift_request;
  logic                             shift_direction;
  logic                             shift_complete;
  // reconfiguration port, apb3 style, no select line
  logic [psrc_pkg::ADDR_W-1:0]      reconfig_address;
  logic                             reconfig_write_enable;
  logic                             reconfig_enable;
  logic [psrc_pkg::DATA_W-1:0]      reconfig_write_data;
  logic [psrc_pkg::DATA_W-1:0]      reconfig_read_data;
  logic                             reconfig_ready;
  modport device (
    input  shift_request,
    input  shift_direction,
    output shift_complete,
    input  reconfig_address,
    input  reconfig_write_enable,
    input  reconfig_enable,
    input  reconfig_write_data,
    output reconfig_read_data,
    output reconfig_ready
  );
  modport host (
    output shift_request,
    output shift_direction,
    input  shift_complete,
    output reconfig_address,
    output reconfig_write_enable,
    output reconfig_enable,
    output reconfig_write_data,
    input  reconfig_read_data,
    input  reconfig_ready
  );
endinterface

// >>> hdl/psrc_interp.sv
`timescale 1ns/10ps
module psrc_interp (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [psrc_pkg::STEP_W-1:0] init_step,
  input  wire logic                        load,
  input  wire logic                        dyn_sel,
  input  wire logic                        use_deskew,
  input  wire logic                        deskew_inc,
  input  wire logic                        deskew_dec,
  input  wire logic                        step_go,
  input  wire logic                        step_up,
  input  wire logic                        slew_en,
  output      logic [psrc_pkg::STEP_W-1:0] phase_step,
  output      logic [psrc_pkg::FRAC_W-1:0] phase_frac
);
  logic [psrc_pkg::STEP_W-1:0] step_q;
  logic [psrc_pkg::FRAC_W-1:0] frac_q;
  logic                        up_q;
  logic                        moving_q;

  // integer step wraps modulo 32, so a full turn always reachable
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      step_q   <= '0;
      frac_q   <= '0;
      up_q     <= 1'b1;
      moving_q <= 1'b0;
    end else if (load) begin
      step_q   <= init_step;
      frac_q   <= '0;
      moving_q <= 1'b0;
    end else if (use_deskew) begin
      // deskew detector steers instead of the shift port
      if (deskew_inc) begin
        step_q <= step_q + 1'b1;
      end else if (deskew_dec) begin
        step_q <= step_q - 1'b1;
      end
    end else if (step_go && dyn_sel) begin
      up_q     <= step_up;
      moving_q <= 1'b1;
      frac_q   <= '0;
    end else if (moving_q && slew_en) begin
      // ramp through sub-steps so the edge moves linearly
      frac_q <= frac_q + 1'b1;
      // commit on the last wait cycle so the new step stands with done
      if (frac_q == psrc_pkg::FRAC_W'(psrc_pkg::SLEW_LAST)) begin
        moving_q <= 1'b0;
        frac_q   <= '0;
        step_q   <= up_q ? step_q + 1'b1 : step_q - 1'b1;
      end
    end
  end

  // reported as signed progress toward the new step
  assign phase_step = step_q;
  assign phase_frac = (moving_q && !up_q) ? psrc_pkg::FRAC_W'(0) - frac_q : frac_q;
endmodule

// >>> hdl/psrc_device.sv
`timescale 1ns/10ps
// Notes on behaviour
// - each divider owns an interpolator, two steering sources
// - one step is vco period over 32
// - phase wraps freely, no overflow
// - per-interpolator initial step, shared shift amount
// - controller keeps the shift clock running
// - feedback shift delays all outputs negatively; only output 0 is reported, as out_rel_feedback
// - handshake synchronous to the shift clock
// - controller pulses request for one cycle
// - direction high increments, low decrements
// - done pulses one cycle, 12 after request
// - controller waits for done before next request
// - output phase slews linearly during a step
// - idle done pulse every 32 cycles
// - unused port held at zero
// - write stores 16-bit data at 7-bit address
// - read returns addressed register contents
// - ready pulses after each completed access
// - port follows apb3 signalling
// - no select, answers every transaction
// - drive port through an axi-lite bridge; psrc_host drives it directly
// - shift only after lock
module psrc_device (
  input  wire logic                                        sys_clk,
  input  wire logic                                        nrst,
  psrc_if.device                                           bus,
  input  wire logic [psrc_pkg::NUM_PI-1:0]                 dyn_select,
  input  wire logic [psrc_pkg::NUM_PI-1:0]                 deskew_select,
  input  wire logic [psrc_pkg::NUM_PI*psrc_pkg::STEP_W-1:0] init_steps,
  input  wire logic                                        load_init,
  input  wire logic                                        deskew1_inc,
  input  wire logic                                        deskew1_dec,
  input  wire logic                                        deskew2_inc,
  input  wire logic                                        deskew2_dec,
  input  wire logic                                        deskew_src2,
  output      logic [psrc_pkg::NUM_PI*psrc_pkg::STEP_W-1:0] phase_steps,
  output      logic [psrc_pkg::NUM_PI*psrc_pkg::FRAC_W-1:0] phase_fracs,
  output      logic [psrc_pkg::STEP_W-1:0]                 out_rel_feedback
);
  psrc_pkg::psrc_ctl_state_type state_q;
  logic [psrc_pkg::CNT_W-1:0]   cnt_q;
  logic                         dir_q;
  logic                         go;
  logic                         done_d;
  logic                         done_q;
  logic                         slew_en;
  logic [psrc_pkg::DATA_W-1:0]  regs_q [psrc_pkg::NUM_REGS];
  logic [psrc_pkg::DATA_W-1:0]  rdata_q;
  logic                         ready_q;
  logic                         pi_inc;
  logic                         pi_dec;

  // request only taken while idle; early ones fall on the floor
  assign go = (state_q == psrc_pkg::PSRC_CTL_IDLE) && bus.shift_request;

  // step sequencer: done lands 12 cycles after the request edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= psrc_pkg::PSRC_CTL_IDLE;
      cnt_q   <= '0;
      dir_q   <= 1'b0;
    end else begin
      case (state_q)
        psrc_pkg::PSRC_CTL_IDLE: begin
          if (go) begin
            dir_q   <= bus.shift_direction;
            cnt_q   <= psrc_pkg::CNT_W'(1);
            state_q <= psrc_pkg::PSRC_CTL_WAIT;
          end else if (cnt_q == psrc_pkg::CNT_W'(psrc_pkg::IDLE_DONE_PERIOD - 1)) begin
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        psrc_pkg::PSRC_CTL_WAIT: begin
          if (cnt_q == psrc_pkg::CNT_W'(psrc_pkg::DONE_LATENCY - 1)) begin
            cnt_q   <= '0;
            state_q <= psrc_pkg::PSRC_CTL_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= psrc_pkg::PSRC_CTL_IDLE;
        end
      endcase
    end
  end

  // done: end of step, or idle heartbeat; registered for a clean edge
  always_comb begin
    done_d = 1'b0;
    if (state_q == psrc_pkg::PSRC_CTL_WAIT) begin
      done_d = (cnt_q == psrc_pkg::CNT_W'(psrc_pkg::DONE_LATENCY - 1));
    end else if (state_q == psrc_pkg::PSRC_CTL_IDLE && !go) begin
      done_d = (cnt_q == psrc_pkg::CNT_W'(psrc_pkg::IDLE_DONE_PERIOD - 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end
  assign bus.shift_complete = done_q;

  // sub-steps advance every cycle of the wait; the step commits with done
  assign slew_en = (state_q == psrc_pkg::PSRC_CTL_WAIT);

  // shared deskew source choice: detector 1 or 2
  assign pi_inc = deskew_src2 ? deskew2_inc : deskew1_inc;
  assign pi_dec = deskew_src2 ? deskew2_dec : deskew1_dec;

  // one interpolator per output divider plus feedback
  genvar gi;
  generate
    for (gi = 0; gi < psrc_pkg::NUM_PI; gi++) begin : g_pi
      psrc_interp u_pi (
        .sys_clk    (sys_clk),
        .nrst       (nrst),
        .init_step  (init_steps[gi*psrc_pkg::STEP_W +: psrc_pkg::STEP_W]),
        .load       (load_init),
        .dyn_sel    (dyn_select[gi]),
        .use_deskew (deskew_select[gi]),
        .deskew_inc (pi_inc),
        .deskew_dec (pi_dec),
        .step_go    (go),
        .step_up    (bus.shift_direction),
        .slew_en    (slew_en),
        .phase_step (phase_steps[gi*psrc_pkg::STEP_W +: psrc_pkg::STEP_W]),
        .phase_frac (phase_fracs[gi*psrc_pkg::FRAC_W +: psrc_pkg::FRAC_W])
      );
    end
  endgenerate

  // output 0 relative to the reference: feedback shift subtracts
  assign out_rel_feedback = phase_steps[0 +: psrc_pkg::STEP_W]
                          - phase_steps[psrc_pkg::FB_IDX*psrc_pkg::STEP_W +: psrc_pkg::STEP_W];

  // register array; no select line, every access phase is ours
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < psrc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= psrc_pkg::REG_RESET;
      end
    end else if (bus.reconfig_enable && bus.reconfig_write_enable) begin
      regs_q[bus.reconfig_address] <= bus.reconfig_write_data;
    end
  end

  // one-wait answer: ready the cycle after enable rises, data from flops
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_q <= '0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b0;
      if (bus.reconfig_enable && !ready_q) begin
        ready_q <= 1'b1;
        if (!bus.reconfig_write_enable) begin
          rdata_q <= regs_q[bus.reconfig_address];
        end
      end
    end
  end
  assign bus.reconfig_ready     = ready_q;
  assign bus.reconfig_read_data = rdata_q;
endmodule

// >>> hdl/psrc_host.sv
`timescale 1ns/10ps
module psrc_host (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  psrc_if.host                             bus,
  input  wire logic                        locked,
  input  wire logic                        step_req,
  input  wire logic                        step_up,
  output      logic                        step_busy,
  input  wire logic                        acc_req,
  input  wire logic                        acc_write,
  input  wire logic [psrc_pkg::ADDR_W-1:0] acc_addr,
  input  wire logic [psrc_pkg::DATA_W-1:0] acc_wdata,
  output      logic                        acc_busy,
  output      logic                        acc_done,
  output      logic [psrc_pkg::DATA_W-1:0] acc_rdata
);
  logic                        req_q;
  logic                        dir_q;
  logic                        wait_q;
  logic                        en_q;
  logic                        we_q;
  logic [psrc_pkg::ADDR_W-1:0] addr_q;
  logic [psrc_pkg::DATA_W-1:0] wdata_q;
  logic                        adone_q;
  logic [psrc_pkg::DATA_W-1:0] ardata_q;

  // one-cycle request, then hold off until done; only once locked
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      req_q  <= 1'b0;
      dir_q  <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      if (wait_q) begin
        if (bus.shift_complete) begin
          wait_q <= 1'b0;
        end
      end else if (step_req && locked) begin
        req_q  <= 1'b1;
        dir_q  <= step_up;
        wait_q <= 1'b1;
      end
    end
  end
  assign bus.shift_request   = req_q;
  assign bus.shift_direction = dir_q;
  assign step_busy           = wait_q;

  // apb3-style master; idle bus parked at zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_q    <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (en_q) begin
      if (bus.reconfig_ready) begin
        en_q    <= 1'b0;
        we_q    <= 1'b0;
        addr_q  <= '0;
        wdata_q <= '0;
      end
    end else if (acc_req) begin
      en_q    <= 1'b1;
      we_q    <= acc_write;
      addr_q  <= acc_addr;
      wdata_q <= acc_write ? acc_wdata : '0;
    end
  end
  assign bus.reconfig_enable       = en_q;
  assign bus.reconfig_write_enable = we_q;
  assign bus.reconfig_address      = addr_q;
  assign bus.reconfig_write_data   = wdata_q;
  assign acc_busy                  = en_q;

  // capture read data on the ready cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      adone_q  <= 1'b0;
      ardata_q <= '0;
    end else begin
      adone_q <= en_q && bus.reconfig_ready;
      if (en_q && bus.reconfig_ready && !we_q) begin
        ardata_q <= bus.reconfig_read_data;
      end
    end
  end
  assign acc_done  = adone_q;
  assign acc_rdata = ardata_q;
endmodule

// >>> testbench/psrc_monitor.sv
`timescale 1ns/10ps
module psrc_monitor (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        shift_request,
  input wire logic        shift_complete,
  input wire logic [6:0]  reconfig_address,
  input wire logic        reconfig_write_enable,
  input wire logic        reconfig_enable,
  input wire logic [15:0] reconfig_write_data,
  input wire logic        reconfig_ready
);
  logic       pend_q;
  logic [5:0] idle_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // step in flight; cleared by its own done
  always_ff @(posedge sys_clk) begin
    if (!nrst || shift_complete) pend_q <= 1'b0;
    else if (shift_request) pend_q <= 1'b1;
  end
  // cycles since last done or request, saturating so it never wraps
  always_ff @(posedge sys_clk) begin
    if (!nrst || shift_complete || shift_request) idle_q <= 6'h00;
    else if (idle_q != 6'h3f) idle_q <= idle_q + 6'h01;
  end
  property p_done_lat; shift_request && !pend_q |-> ##12 shift_complete; endproperty
  property p_done_quiet; shift_request && !pend_q |=> (!shift_complete)[*8]; endproperty
  property p_done_one; shift_complete |=> !shift_complete; endproperty
  property p_req_one; shift_request |=> !shift_request; endproperty
  property p_req_wait; pend_q |-> !shift_request; endproperty
  property p_idle_gap; shift_complete && !pend_q |-> idle_q > 6'h1b && idle_q < 6'h21; endproperty
  property p_idle_max; idle_q < 6'h21; endproperty
  property p_rdy_next; reconfig_enable && !reconfig_ready |=> reconfig_ready; endproperty
  property p_rdy_one; reconfig_ready |=> !reconfig_ready; endproperty
  property p_en_drop; reconfig_ready |=> !reconfig_enable; endproperty
  property p_hold;
    reconfig_enable && !reconfig_ready |=> $stable(reconfig_address)
      && $stable(reconfig_write_data) && $stable(reconfig_write_enable);
  endproperty
  a_done_lat: assert property (p_done_lat) else $error("done latency wrong");
  a_done_quiet: assert property (p_done_quiet) else $error("done too early");
  a_done_one: assert property (p_done_one) else $error("done too long");
  a_req_one: assert property (p_req_one) else $error("request too long");
  a_req_wait: assert property (p_req_wait) else $error("request before done");
  a_idle_gap: assert property (p_idle_gap) else $error("idle done spacing");
  a_idle_max: assert property (p_idle_max) else $error("idle done missing");
  a_rdy_next: assert property (p_rdy_next) else $error("ready late");
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  a_en_drop: assert property (p_en_drop) else $error("enable not dropped");
  a_hold: assert property (p_hold) else $error("access changed early");
  c_step: cover property (shift_request ##12 shift_complete);
  c_idle: cover property (shift_complete && !pend_q);
  c_write: cover property (reconfig_enable && reconfig_write_enable ##1 reconfig_ready);
  c_read: cover property (reconfig_enable && !reconfig_write_enable ##1 reconfig_ready);
endmodule

// >>> testbench/test_pll_phase_shift_and_reconfig_port.sv
`timescale 1ns/10ps
module test_pll_phase_shift_and_reconfig_port;
  logic        sys_clk, nrst, locked, step_req, step_up, busy_s, busy_a, acc_done;
  logic        acc_req, acc_write, load_init, dsk_inc;
  logic [6:0]  acc_addr;
  logic [15:0] acc_wdata, acc_rdata;
  logic [7:0]  dyn_select, deskew_select;
  logic [39:0] init_steps, steps;
  logic [31:0] fracs;
  logic [4:0]  rel;
  int          num_errors, checks_done, cycles, n;
  psrc_if bus();
  psrc_device psrc_device_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
    .dyn_select(dyn_select), .deskew_select(deskew_select), .init_steps(init_steps),
    .load_init(load_init), .deskew1_inc(dsk_inc), .deskew1_dec(1'b0), .deskew2_inc(1'b0),
    .deskew2_dec(1'b0), .deskew_src2(1'b0), .phase_steps(steps), .phase_fracs(fracs),
    .out_rel_feedback(rel));
  psrc_host psrc_host_inst (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .locked(locked),
    .step_req(step_req), .step_up(step_up), .step_busy(busy_s), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_busy(busy_a),
    .acc_done(acc_done), .acc_rdata(acc_rdata));
  psrc_monitor psrc_monitor_inst (.sys_clk(sys_clk), .nrst(nrst),
    .shift_request(bus.shift_request), .shift_complete(bus.shift_complete),
    .reconfig_address(bus.reconfig_address), .reconfig_write_enable(bus.reconfig_write_enable),
    .reconfig_enable(bus.reconfig_enable), .reconfig_write_data(bus.reconfig_write_data),
    .reconfig_ready(bus.reconfig_ready));
  // shift clock always running
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // whole run is well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("mismatch at %0t: run hung", $time);
      conclude();
    end
  end
  task conclude();
    $display("%0d checks, %0d mismatches", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk_step(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: step %h expected %h", $time, got, exp);
    end
  endtask
  task chk_data(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] st(input int i);
    return steps[i*5 +: 5];
  endfunction
  // one step through the host; e0/e1/e7 are the steps expected afterwards
  task do_step(input logic up, input logic [4:0] e0, input logic [4:0] e1,
               input logic [4:0] e7);
    n = 0;
    step_up = up;
    step_req = 1'b1;
    while (bus.shift_request !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_flag(bus.shift_direction, up);
    chk_flag(busy_s, 1'b1);
    step_req = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_flag(fracs[3:0] != 4'h0, 1'b1);
    chk_step(st(0), up ? e0 - 5'h01 : e0 + 5'h01);
    n = 0;
    while (bus.shift_complete !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_step(st(0), e0);
    chk_step(st(1), e1);
    chk_step(st(7), e7);
    chk_step(rel, e0 - e7);
    $display("step test ended");
  endtask
  task acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    acc_req = 1'b1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    @(negedge sys_clk);
    acc_req = 1'b0;
    n = 0;
    while (acc_done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk_flag(acc_done, 1'b1);
    chk_flag(busy_a, 1'b0);
    if (!w) chk_data(acc_rdata, d);
    @(negedge sys_clk);
    chk_flag(bus.reconfig_enable, 1'b0);
  endtask
  initial begin
    {nrst, locked, step_req, step_up, acc_req, acc_write, load_init, dsk_inc} = 8'h00;
    acc_addr = 7'h00;
    acc_wdata = 16'h0000;
    deskew_select = 8'h00;
    dyn_select = 8'h81;
    init_steps = 40'h100000009f;
    repeat (3) @(negedge sys_clk);
    chk_step(st(0), 5'h00);
    chk_flag(bus.reconfig_ready, 1'b0);
    nrst = 1'b1;
    load_init = 1'b1;
    @(negedge sys_clk);
    load_init = 1'b0;
    @(negedge sys_clk);
    chk_step(st(0), 5'h1f);
    chk_step(st(1), 5'h04);
    chk_step(st(7), 5'h02);
    $display("init test ended");
    // no shifting before lock
    step_req = 1'b1;
    n = 0;
    repeat (20) @(negedge sys_clk) if (bus.shift_request === 1'b1) n++;
    step_req = 1'b0;
    chk_step(5'(n), 5'h00);
    locked = 1'b1;
    @(negedge sys_clk);
    do_step(1'b1, 5'h00, 5'h04, 5'h03);
    do_step(1'b0, 5'h1f, 5'h04, 5'h02);
    n = 0;
    repeat (100) @(negedge sys_clk) if (bus.shift_complete === 1'b1) n++;
    chk_step(5'(n), 5'h03);
    chk_flag(busy_s, 1'b0);
    $display("idle test ended");
    deskew_select = 8'h02;
    dsk_inc = 1'b1;
    @(negedge sys_clk);
    dsk_inc = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_step(st(1), 5'h05);
    $display("deskew test ended");
    acc(1'b1, 7'h00, 16'h1234);
    acc(1'b1, 7'h7f, 16'hbeef);
    acc(1'b0, 7'h00, 16'h1234);
    acc(1'b0, 7'h7f, 16'hbeef);
    acc(1'b0, 7'h05, psrc_pkg::REG_RESET);
    $display("port test ended");
    conclude();
  end
endmodule
